// >>> logic/mcl_pkg.sv
/*
 math chain and condition logic: shared types, offsets, reset values.
 assumes an APB master on pclk and same-clock producers and consumers.
*/
// Summary of operation
// - four inputs scaled to percent by limits
// - signed weight per input, default one
// - four cascaded stages, result feeds operand A
// - unused operand B passes operand A
// - codes 0-5 give comparison truth
// - codes 6-8 give OR, AND, XOR
// - codes 9-12 give sum, difference, product, quotient
// - codes 13-15 give min, max, distance
// - divide by zero yields zero
// - negative difference clamps to zero
// - logic unit idle until enabled, default off
// - selected table output forwarded unchanged
// - tables checked ascending, lowest true table wins
// - three conditions per table, constant allowed
// - condition operator stored only with both arguments, else zero
// - condition codes 0-5 select comparison
// - condition result false, true, error, unavailable
// - both arguments unused gives unavailable
// - combine codes default, all, any, mixed
// - tables one, two all-true; three default
package mcl_pkg;
    typedef struct packed {
        logic [1:0] st;
        logic [31:0] val;
    } mcl_sig_t;
    typedef enum logic [3:0] {
        OP_EQ = 4'h0, OP_NE = 4'h1, OP_GT = 4'h2, OP_GE = 4'h3,
        OP_LT = 4'h4, OP_LE = 4'h5, OP_OR = 4'h6, OP_AND = 4'h7,
        OP_XOR = 4'h8, OP_ADD = 4'h9, OP_SUB = 4'hA, OP_MUL = 4'hB,
        OP_DIV = 4'hC, OP_MIN = 4'hD, OP_MAX = 4'hE, OP_ABD = 4'hF
    } mcl_op_t;
    typedef enum logic [2:0] {
        CMB_DEF = 3'h0, CMB_ALL = 3'h1, CMB_ANY = 3'h2,
        CMB_AOR = 3'h3, CMB_OAND = 3'h4
    } mcl_comb_t;
    typedef enum logic [1:0] {
        CR_FALSE = 2'h0, CR_TRUE = 2'h1, CR_ERR = 2'h2, CR_NA = 2'h3
    } mcl_cres_t;
    localparam logic [1:0] ST_OK = 2'h0;
    localparam logic [1:0] ST_ERR = 2'h2;
    localparam logic [1:0] ST_NA = 2'h3;
    localparam logic [3:0] SRC_NONE = 4'h0;
    localparam logic [3:0] SRC_LAST = 4'h8;
    localparam logic [3:0] SRC_CONST = 4'h9;
    localparam logic [2:0] MSRC_NONE = 3'h0;
    localparam int CF_A1 = 0;
    localparam int CF_A2 = 4;
    localparam int CF_OP = 8;
    localparam logic [31:0] PCT_FULL = 32'h000003E8;
    localparam logic [31:0] W_SCALE = 32'h0000000A;
    localparam logic [31:0] TRUE_VAL = 32'h000003E8;
    localparam logic [31:0] RST_LIM = 32'hFFFF0000;
    localparam logic [15:0] RST_WGT = 16'h000A;
    localparam logic [8:0] RST_MODE = 9'h009;
    localparam logic [7:0] A_OPS = 8'h00;
    localparam logic [7:0] A_SRCS = 8'h04;
    localparam logic [7:0] A_LIM = 8'h08;
    localparam logic [7:0] A_WGT = 8'h18;
    localparam logic [7:0] A_MRES = 8'h28;
    localparam logic [7:0] A_EN = 8'h2C;
    localparam logic [7:0] A_MODE = 8'h30;
    localparam logic [7:0] A_COND = 8'h34;
    localparam logic [7:0] A_CONST = 8'h58;
    localparam logic [7:0] A_STAT = 8'h64;
    localparam logic [7:0] A_LOUT = 8'h68;
endpackage

// >>> logic/mcl_top.sv
/*
 math chain and programmable logic condition evaluator with APB registers.
 assumes inputs come from logic on pclk; apb master per protocol.
*/
`timescale 1ns/1ps
module mcl_top (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [3:0][15:0] math_in,
    input wire mcl_pkg::mcl_sig_t [7:0] logic_src,
    input wire mcl_pkg::mcl_sig_t [2:0] table_in,
    output logic [31:0] math_out,
    output mcl_pkg::mcl_sig_t logic_out,
    output logic [1:0] sel_table
);

    ////////////////////////////////////////////////////////////////////
    // helper functions
    function automatic logic hit_f(input logic [7:0] a,
                                   input logic [7:0] base,
                                   input int n);
        hit_f = (int'(a) >= int'(base)) && (int'(a) < int'(base) + 4 * n)
                && (a[1:0] == 2'h0);
    endfunction

    // signed comparison shared by math and conditions
    function automatic logic cmp_f(input logic [2:0] op,
                                   input logic [31:0] a,
                                   input logic [31:0] b);
        logic signed [31:0] sa;
        logic signed [31:0] sb;
        sa = a;
        sb = b;
        case (op)
            3'h0: cmp_f = (sa == sb);
            3'h1: cmp_f = (sa != sb);
            3'h2: cmp_f = (sa > sb);
            3'h3: cmp_f = (sa >= sb);
            3'h4: cmp_f = (sa < sb);
            3'h5: cmp_f = (sa <= sb);
            default: cmp_f = 1'b0;
        endcase
    endfunction

    function automatic logic [31:0] bool_f(input logic t);
        bool_f = t ? mcl_pkg::TRUE_VAL : 32'h0;
    endfunction

    // one operator stage
    function automatic logic [31:0] alu_f(input logic [3:0] op,
                                          input logic [31:0] a,
                                          input logic [31:0] b);
        logic signed [31:0] sa;
        logic signed [31:0] sb;
        logic signed [31:0] d;
        logic signed [63:0] p;
        logic signed [63:0] full;
        logic ta;
        logic tb;
        sa = a;
        sb = b;
        d = sa - sb;
        full = $signed(64'(mcl_pkg::PCT_FULL));
        p = 64'(sa) * 64'(sb);
        ta = (a != 32'h0);
        tb = (b != 32'h0);
        case (mcl_pkg::mcl_op_t'(op))
            mcl_pkg::OP_OR: alu_f = bool_f(ta | tb);
            mcl_pkg::OP_AND: alu_f = bool_f(ta & tb);
            mcl_pkg::OP_XOR: alu_f = bool_f(ta ^ tb);
            mcl_pkg::OP_ADD: alu_f = 32'(sa + sb);
            mcl_pkg::OP_SUB: alu_f = (d < 0) ? 32'h0 : d;
            mcl_pkg::OP_MUL: alu_f = 32'(p / full);
            mcl_pkg::OP_DIV: begin
                if (sb == 0) begin
                    alu_f = 32'h0;
                end else begin
                    alu_f = 32'((64'(sa) * full) / 64'(sb));
                end
            end
            mcl_pkg::OP_MIN: alu_f = (sa < sb) ? a : b;
            mcl_pkg::OP_MAX: alu_f = (sa > sb) ? a : b;
            mcl_pkg::OP_ABD: alu_f = (d < 0) ? 32'(-d) : d;
            default: alu_f = bool_f(cmp_f(op[2:0], a, b));
        endcase
    endfunction

    // logic source picker, codes outside range are unavailable
    function automatic mcl_pkg::mcl_sig_t pick_f(input logic [3:0] c);
        if (c != mcl_pkg::SRC_NONE && c <= mcl_pkg::SRC_LAST) begin
            pick_f = logic_src[c - 4'h1];
        end else begin
            pick_f = {mcl_pkg::ST_NA, 32'h0};
        end
    endfunction

    // table combine with unavailable counted true only for all-true
    function automatic logic comb_f(input logic [2:0] m,
                                    input logic [1:0] r1,
                                    input logic [1:0] r2,
                                    input logic [1:0] r3);
        logic t1;
        logic t2;
        logic t3;
        logic n1;
        logic n2;
        logic n3;
        t1 = (r1 == mcl_pkg::CR_TRUE);
        t2 = (r2 == mcl_pkg::CR_TRUE);
        t3 = (r3 == mcl_pkg::CR_TRUE);
        n1 = t1 | (r1 == mcl_pkg::CR_NA);
        n2 = t2 | (r2 == mcl_pkg::CR_NA);
        n3 = t3 | (r3 == mcl_pkg::CR_NA);
        case (mcl_pkg::mcl_comb_t'(m))
            mcl_pkg::CMB_DEF: comb_f = 1'b1;
            mcl_pkg::CMB_ALL: comb_f = n1 & n2 & n3;
            mcl_pkg::CMB_ANY: comb_f = t1 | t2 | t3;
            mcl_pkg::CMB_AOR: comb_f = (t1 & t2) | t3;
            mcl_pkg::CMB_OAND: comb_f = (t1 | t2) & t3;
            default: comb_f = 1'b0;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////
    // configuration registers
    logic [15:0] ops_r;
    logic [14:0] srcs_r;
    logic [3:0][31:0] lim_r;
    logic [3:0][15:0] wgt_r;
    logic en_r;
    logic [8:0] mode_r;
    logic [8:0][10:0] cond_r;
    logic [2:0][31:0] konst_r;
    logic [31:0] rd_data;

    // apb decode
    wire wr = psel & penable & pwrite;
    wire setup = psel & ~penable;
    wire h_ops = (paddr == mcl_pkg::A_OPS);
    wire h_srcs = (paddr == mcl_pkg::A_SRCS);
    wire h_lim = hit_f(paddr, mcl_pkg::A_LIM, 4);
    wire h_wgt = hit_f(paddr, mcl_pkg::A_WGT, 4);
    wire h_mres = (paddr == mcl_pkg::A_MRES);
    wire h_en = (paddr == mcl_pkg::A_EN);
    wire h_mode = (paddr == mcl_pkg::A_MODE);
    wire h_cond = hit_f(paddr, mcl_pkg::A_COND, 9);
    wire h_const = hit_f(paddr, mcl_pkg::A_CONST, 3);
    wire h_stat = (paddr == mcl_pkg::A_STAT);
    wire h_lout = (paddr == mcl_pkg::A_LOUT);
    wire mapped = h_ops | h_srcs | h_lim | h_wgt | h_mres | h_en | h_mode
                  | h_cond | h_const | h_stat | h_lout;
    wire [7:0] d_lim = paddr - mcl_pkg::A_LIM;
    wire [7:0] d_wgt = paddr - mcl_pkg::A_WGT;
    wire [7:0] d_cond = paddr - mcl_pkg::A_COND;
    wire [7:0] d_const = paddr - mcl_pkg::A_CONST;
    wire [1:0] i_lim = d_lim[3:2];
    wire [1:0] i_wgt = d_wgt[3:2];
    wire [3:0] i_cond = d_cond[5:2];
    wire [1:0] i_const = d_const[3:2];

    // zero wait states, error only in access to a hole
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~mapped;

    // scalar registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ops_r <= 16'h0000;
            srcs_r <= 15'h0000;
            en_r <= 1'b0;
            mode_r <= mcl_pkg::RST_MODE;
        end else if (wr) begin
            if (h_ops) ops_r <= pwdata[15:0];
            if (h_srcs) srcs_r <= pwdata[14:0];
            if (h_en) en_r <= pwdata[0];
            if (h_mode) mode_r <= pwdata[8:0];
        end
    end

    // per input limits and weights
    genvar gi;
    for (gi = 0; gi < 4; gi++) begin : g_inreg
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                lim_r[gi] <= mcl_pkg::RST_LIM;
                wgt_r[gi] <= mcl_pkg::RST_WGT;
            end else if (wr) begin
                if (h_lim && i_lim == 2'(gi)) lim_r[gi] <= pwdata;
                if (h_wgt && i_wgt == 2'(gi)) wgt_r[gi] <= pwdata[15:0];
            end
        end
    end

    // condition words, operator kept only with two arguments
    genvar gc;
    for (gc = 0; gc < 9; gc++) begin : g_condreg
        wire [3:0] w1 = pwdata[mcl_pkg::CF_A1 +: 4];
        wire [3:0] w2 = pwdata[mcl_pkg::CF_A2 +: 4];
        wire both = (w1 != mcl_pkg::SRC_NONE) && (w2 != mcl_pkg::SRC_NONE);
        wire [2:0] wop = both ? pwdata[mcl_pkg::CF_OP +: 3] : 3'h0;
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                cond_r[gc] <= 11'h000;
            end else if (wr && h_cond && i_cond == 4'(gc)) begin
                cond_r[gc] <= {wop, w2, w1};
            end
        end
    end

    for (gi = 0; gi < 3; gi++) begin : g_konst
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                konst_r[gi] <= 32'h0;
            end else if (wr && h_const && i_const == 2'(gi)) begin
                konst_r[gi] <= pwdata;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // math chain
    logic [3:0][31:0] pct;
    logic [3:0][31:0] wtd;
    logic [7:0][31:0] opnd;
    logic [3:0][31:0] stg_a;
    logic [3:0][31:0] stg_b;
    logic [3:0][31:0] res;

    // percent in tenths, then weight in tenths
    for (gi = 0; gi < 4; gi++) begin : g_scale
        wire [15:0] x = math_in[gi];
        wire [15:0] mn = lim_r[gi][15:0];
        wire [15:0] mx = lim_r[gi][31:16];
        wire [31:0] num = 32'(x - mn) * mcl_pkg::PCT_FULL;
        wire [31:0] den = 32'(mx - mn);
        wire signed [31:0] w = 32'(signed'(wgt_r[gi]));
        assign pct[gi] = (mx <= mn || x <= mn) ? 32'h0 :
                         (x >= mx) ? mcl_pkg::PCT_FULL : num / den;
        assign wtd[gi] = 32'($signed(pct[gi]) * w
                             / $signed(mcl_pkg::W_SCALE));
    end

    // source 0 unused, 1..4 weighted inputs
    assign opnd = {96'h0, wtd, 32'h0};

    genvar gk;
    for (gk = 0; gk < 4; gk++) begin : g_stage
        wire [2:0] bs = srcs_r[3 * gk + 3 +: 3];
        wire [3:0] op = ops_r[4 * gk +: 4];
        if (gk == 0) begin : g_first
            assign stg_a[gk] = opnd[srcs_r[2:0]];
        end else begin : g_next
            assign stg_a[gk] = res[gk - 1];
        end
        assign stg_b[gk] = opnd[bs];
        assign res[gk] = (bs == mcl_pkg::MSRC_NONE) ? stg_a[gk]
                         : alu_f(op, stg_a[gk], stg_b[gk]);
    end

    ////////////////////////////////////////////////////////////////////
    // condition evaluation, nine conditions
    logic [8:0][1:0] cres;
    logic [2:0] tsel;

    for (gc = 0; gc < 9; gc++) begin : g_cond
        wire [3:0] a1 = cond_r[gc][mcl_pkg::CF_A1 +: 4];
        wire [3:0] a2 = cond_r[gc][mcl_pkg::CF_A2 +: 4];
        wire [2:0] cop = cond_r[gc][mcl_pkg::CF_OP +: 3];
        mcl_pkg::mcl_sig_t s1;
        mcl_pkg::mcl_sig_t s2;
        assign s1 = pick_f(a1);
        assign s2 = (a2 == mcl_pkg::SRC_CONST) ?
                    {mcl_pkg::ST_OK, konst_r[gc / 3]} : pick_f(a2);
        assign cres[gc] =
            (a1 == mcl_pkg::SRC_NONE && a2 == mcl_pkg::SRC_NONE) ?
                mcl_pkg::CR_NA :
            (s1.st == mcl_pkg::ST_ERR || s2.st == mcl_pkg::ST_ERR) ?
                mcl_pkg::CR_ERR :
            (s1.st == mcl_pkg::ST_NA || s2.st == mcl_pkg::ST_NA) ?
                mcl_pkg::CR_NA :
            cmp_f(cop, s1.val, s2.val) ?
                mcl_pkg::CR_TRUE : mcl_pkg::CR_FALSE;
    end

    for (gk = 0; gk < 3; gk++) begin : g_table
        assign tsel[gk] = comb_f(mode_r[3 * gk +: 3], cres[3 * gk],
                                 cres[3 * gk + 1], cres[3 * gk + 2]);
    end

    // ascending priority, zero means no table
    wire [1:0] next_sel = !en_r ? 2'h0 :
                          tsel[0] ? 2'h1 : tsel[1] ? 2'h2 :
                          tsel[2] ? 2'h3 : 2'h0;
    mcl_pkg::mcl_sig_t sel_in;
    mcl_pkg::mcl_sig_t next_out;
    assign sel_in = table_in[(next_sel == 2'h0) ? 2'h0 : next_sel - 2'h1];
    assign next_out = (next_sel == 2'h0) ? {mcl_pkg::ST_NA, 32'h0}
                      : sel_in;

    // registered results
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            math_out <= 32'h0;
            logic_out <= {mcl_pkg::ST_NA, 32'h0};
            sel_table <= 2'h0;
        end else begin
            math_out <= res[3];
            logic_out <= next_out;
            sel_table <= next_sel;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // read mux, captured in setup so data is ready in access
    always_comb begin
        rd_data = 32'h0;
        if (h_ops) rd_data = {16'h0, ops_r};
        if (h_srcs) rd_data = {17'h0, srcs_r};
        if (h_lim) rd_data = lim_r[i_lim];
        if (h_wgt) rd_data = {16'h0, wgt_r[i_wgt]};
        if (h_mres) rd_data = math_out;
        if (h_en) rd_data = {31'h0, en_r};
        if (h_mode) rd_data = {23'h0, mode_r};
        if (h_cond && i_cond < 4'h9) rd_data = {21'h0, cond_r[i_cond]};
        if (h_const && i_const < 2'h3) rd_data = konst_r[i_const];
        if (h_stat) rd_data = {12'h0, sel_table, cres};
        if (h_lout) rd_data = logic_out.val;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0;
        end else if (setup && !pwrite) begin
            prdata <= rd_data;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // assertions
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_access;
        psel && penable;
    endsequence

    apb_ready_a: assert property (s_setup ##1 s_access |-> pready)
        else $error("access not answered at once");
    hole_error_a: assert property (psel && penable && !mapped |-> pslverr)
        else $error("unmapped access not flagged");
    pct_range_a: assert property ($signed(pct[0]) >= 0 &&
        $signed(pct[0]) <= $signed(mcl_pkg::PCT_FULL))
        else $error("percent out of range");
    unit_weight_a: assert property (wgt_r[1] == mcl_pkg::RST_WGT
        |-> wtd[1] == pct[1])
        else $error("unit weight changed value");
    pass_chain_a: assert property (srcs_r[14:6] == 9'h0
        |=> math_out == $past(res[0]))
        else $error("unused stages altered result");
    cmp_bool_a: assert property (ops_r[3:0] <= 4'h5
        |-> res[0] == 32'h0 || res[0] == mcl_pkg::TRUE_VAL
            || srcs_r[5:3] == 3'h0)
        else $error("comparison not boolean");
    div_zero_a: assert property (ops_r[3:0] == mcl_pkg::OP_DIV
        && srcs_r[5:3] != 3'h0 && stg_b[0] == 32'h0 |-> res[0] == 32'h0)
        else $error("divide by zero not zero");
    sub_clamp_a: assert property (ops_r[3:0] == mcl_pkg::OP_SUB
        && srcs_r[5:3] != 3'h0 |-> !res[0][31])
        else $error("difference went negative");
    off_idle_a: assert property (!en_r |=>
        sel_table == 2'h0 && logic_out.st == mcl_pkg::ST_NA)
        else $error("disabled unit produced output");
    forward_a: assert property (next_sel != 2'h0
        |=> logic_out == $past(sel_in))
        else $error("table output not forwarded");
    first_pick_a: assert property (en_r && tsel[0]
        |=> sel_table == 2'h1)
        else $error("lower table not preferred");
    op_guard_a: assert property (cond_r[0][10:8] != 3'h0 |->
        cond_r[0][3:0] != 4'h0 && cond_r[0][7:4] != 4'h0)
        else $error("operator set without arguments");
    cond_off_a: assert property (cond_r[4][7:0] == 8'h00
        |-> cres[4] == mcl_pkg::CR_NA)
        else $error("unused condition not unavailable");
    none_na_a: assert property (en_r && tsel == 3'h0
        |=> logic_out.st == mcl_pkg::ST_NA && sel_table == 2'h0)
        else $error("no table but output available");

endmodule

// >>> bench/mcl_partner.sv
/*
 far-side model: function blocks feeding logic sources and table outputs.
 assumes pclk from the bench; values move just after each rising edge.
*/
`timescale 1ns/1ps
module mcl_partner (
    input wire logic pclk,
    input wire logic err_en,
    output mcl_pkg::mcl_sig_t [7:0] logic_src,
    output mcl_pkg::mcl_sig_t [2:0] table_in
);
    int seed = 32'h4292c38f;
    logic [1:0] st;
    // sources stay in a narrow band so equal values are common
    always @(posedge pclk) begin
        for (int i = 0; i < 8; i++) begin
            st = 2'($random(seed));
            logic_src[i].st <= (err_en && st != 2'h1) ? st : 2'h0;
            logic_src[i].val <= $random(seed) % 4;
        end
        // table outputs change every cycle
        for (int i = 0; i < 3; i++) begin
            table_in[i] <= {2'($random(seed)), $random(seed)};
        end
    end
endmodule

// >>> bench/tb_top.sv
/*
 self-checking bench: apb configuration, random inputs, reference model.
 assumes zero-wait apb and outputs one edge after their inputs.
*/
`timescale 1ns/1ps
module tb_top;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err_en, e;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, math_out, q, exp_m;
    logic [3:0][15:0] math_in;
    mcl_pkg::mcl_sig_t [7:0] logic_src;
    mcl_pkg::mcl_sig_t [2:0] table_in;
    mcl_pkg::mcl_sig_t logic_out, exp_lo;
    logic [1:0] sel_table, exp_sel;
    logic [31:0] m_reg [64];
    logic [3:0] codes [4] = '{4'h9, 4'hA, 4'hD, 4'hE};
    int seed = 32'h4292c38f;
    int failures = 0;
    int n_compared = 0;
    logic chk = 0;

    mcl_top u_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .math_in(math_in), .logic_src(logic_src), .table_in(table_in),
        .math_out(math_out), .logic_out(logic_out), .sel_table(sel_table));
    mcl_partner u_far (.pclk(pclk), .err_en(err_en),
        .logic_src(logic_src), .table_in(table_in));

    ////////////////////////////////////////////////////////////////////////
    // clock
    initial begin
        pclk = 0;
        forever #20 pclk = ~pclk;
    end

    task automatic check(input logic [35:0] got, input logic [35:0] exp,
                         input string what);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: %s %h not %h", $time, what, got,
                     exp);
        end
    endtask

    task automatic results();
        if (failures == 0 && n_compared > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    function automatic logic [31:0] rnd(int n);
        return ($random(seed) & 32'h7FFFFFFF) % n;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // reference model of the math chain
    function automatic longint wgt_in(int i);
        longint x, lo, hi, p;
        x = math_in[i];
        lo = m_reg[2+i][15:0];
        hi = m_reg[2+i][31:16];
        if (hi <= lo || x <= lo) p = 0;
        else if (x >= hi) p = 1000;
        else p = (x - lo) * 1000 / (hi - lo);
        return p * $signed(m_reg[6+i][15:0]) / 10;
    endfunction

    function automatic longint op(logic [3:0] c, longint a, longint b);
        case (c)
            4'h0: return (a == b) ? 1000 : 0;
            4'h1: return (a != b) ? 1000 : 0;
            4'h2: return (a > b) ? 1000 : 0;
            4'h3: return (a >= b) ? 1000 : 0;
            4'h4: return (a < b) ? 1000 : 0;
            4'h5: return (a <= b) ? 1000 : 0;
            4'h6: return (a != 0 || b != 0) ? 1000 : 0;
            4'h7: return (a != 0 && b != 0) ? 1000 : 0;
            4'h8: return ((a != 0) != (b != 0)) ? 1000 : 0;
            4'h9: return a + b;
            4'hA: return (a > b) ? a - b : 0;
            4'hB: return a * b / 1000;
            4'hC: return (b == 0) ? 0 : a * 1000 / b;
            4'hD: return (a < b) ? a : b;
            4'hE: return (a > b) ? a : b;
            default: return (a > b) ? a - b : b - a;
        endcase
    endfunction

    function automatic logic [31:0] chain();
        int v [5];
        int a;
        logic [2:0] s;
        v[0] = 0;
        for (int i = 0; i < 4; i++) v[i+1] = int'(wgt_in(i));
        a = (m_reg[1][2:0] <= 4) ? v[m_reg[1][2:0]] : 0;
        for (int k = 0; k < 4; k++) begin
            s = m_reg[1][3*k+3 +: 3];
            if (s != 0)
                a = int'(op(m_reg[0][4*k +: 4], a, (s <= 4) ? v[s] : 0));
        end
        return a;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // reference model of the logic unit
    function automatic logic [1:0] cond(int t, int c);
        logic [31:0] f;
        int a, b;
        mcl_pkg::mcl_sig_t x [2];
        f = m_reg[13+3*t+c];
        if (f[7:0] == 0) return 2'h3;
        for (int j = 0; j < 2; j++) begin
            x[j] = {2'h3, 32'h00000000};
            if (f[4*j +: 4] inside {[1:8]}) x[j] = logic_src[f[4*j +: 4]-1];
            if (j == 1 && f[7:4] == 9) x[j] = {2'h0, m_reg[22+t]};
        end
        if (x[0].st == 2'h2 || x[1].st == 2'h2) return 2'h2;
        if (x[0].st != 0 || x[1].st != 0) return 2'h3;
        a = x[0].val;
        b = x[1].val;
        case (f[10:8])
            3'h0: return {1'b0, a == b};
            3'h1: return {1'b0, a != b};
            3'h2: return {1'b0, a > b};
            3'h3: return {1'b0, a >= b};
            3'h4: return {1'b0, a < b};
            3'h5: return {1'b0, a <= b};
            default: return 2'h0;
        endcase
    endfunction

    function automatic logic [35:0] plu();
        logic [1:0] r [3];
        logic hit;
        if (!m_reg[11][0]) return {4'h3, 32'h00000000};
        for (int t = 0; t < 3; t++) begin
            for (int c = 0; c < 3; c++) r[c] = cond(t, c);
            case (m_reg[12][3*t +: 3])
                3'h0: hit = 1;
                3'h1: hit = r[0][0] && r[1][0] && r[2][0];
                3'h2: hit = r[0] == 1 || r[1] == 1 || r[2] == 1;
                3'h3: hit = (r[0] == 1 && r[1] == 1) || r[2] == 1;
                3'h4: hit = (r[0] == 1 || r[1] == 1) && r[2] == 1;
                default: hit = 0;
            endcase
            if (hit) return {2'(t + 1), table_in[t]};
        end
        return {4'h3, 32'h00000000};
    endfunction

    // expected outputs one edge after their inputs
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            exp_m <= 0;
            {exp_sel, exp_lo} <= {4'h3, 32'h00000000};
        end else begin
            exp_m <= chain();
            {exp_sel, exp_lo} <= plu();
        end
    end

    // compare every settled result
    always @(negedge pclk) begin
        if (chk) begin
            check({4'h0, math_out}, {4'h0, exp_m}, "math");
            check({sel_table, logic_out}, {exp_sel, exp_lo}, "logic");
        end
    end

    // raw inputs change every cycle
    always @(posedge pclk) math_in <= {$random(seed), $random(seed)};

    ////////////////////////////////////////////////////////////////////////
    // apb master
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge pclk);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 0;
        penable <= 0;
        if (w && a >= 8'h34 && a < 8'h58 && (d[3:0] == 0 || d[7:4] == 0))
            d[10:8] = 3'h0;
        if (w && a < 8'h68) m_reg[a[7:2]] <= d;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        foreach (m_reg[i]) m_reg[i] = 0;
        for (int i = 0; i < 4; i++) m_reg[2+i] = mcl_pkg::RST_LIM;
        for (int i = 0; i < 4; i++) m_reg[6+i] = 32'h0000000A;
        m_reg[12] = 32'h00000009;
        {presetn, psel, penable, pwrite, paddr, pwdata, err_en} = '0;
        math_in = '0;
        repeat (8) @(posedge pclk);
        presetn <= 1;
        chk <= 1;
        for (int i = 0; i < 4; i++) begin
            apb(0, mcl_pkg::A_LIM + 8'(4 * i), 0);
            check(q, mcl_pkg::RST_LIM, "limit reset");
            apb(0, mcl_pkg::A_WGT + 8'(4 * i), 0);
            check(q, 32'h0000000A, "weight reset");
        end
        apb(0, mcl_pkg::A_EN, 0);
        check(q, 32'h00000000, "enable reset");
        apb(0, mcl_pkg::A_MODE, 0);
        check(q, 32'h00000009, "mode reset");
        apb(0, 8'h6C, 0);
        check({e, q}, {1'b1, 32'h00000000}, "unmapped");
        for (int i = 0; i < 150; i++) begin
            apb(1, mcl_pkg::A_OPS, (i < 4) ? 32'(codes[i]) : $random(seed));
            apb(1, mcl_pkg::A_SRCS, (i < 4) ? 32'h11 : rnd(8) + 8 * rnd(8)
                + 64 * rnd(8) + 512 * rnd(8) + 4096 * rnd(8));
            for (int k = 0; k < 4; k++) begin
                apb(1, mcl_pkg::A_LIM + 8'(4 * k), $random(seed));
                apb(1, mcl_pkg::A_WGT + 8'(4 * k), (i < 4) ?
                    (k[0] ? 32'hFC18 : 32'h03E8) : rnd(41) - 20);
            end
            repeat (10) @(posedge pclk);
        end
        apb(1, mcl_pkg::A_EN, 1);
        for (int i = 0; i < 150; i++) begin
            err_en <= i[0];
            apb(1, mcl_pkg::A_MODE, $random(seed));
            for (int c = 0; c < 9; c++)
                apb(1, mcl_pkg::A_COND + 8'(4 * c),
                    rnd(8) * 256 + rnd(11) * 16 + rnd(11));
            for (int t = 0; t < 3; t++)
                apb(1, mcl_pkg::A_CONST + 8'(4 * t), $random(seed) % 4);
            apb(0, mcl_pkg::A_COND + 8'(4 * (i % 9)), 0);
            check({e, q}, {1'b0, m_reg[13 + i % 9]}, "condition");
            repeat (10) @(posedge pclk);
        end
        results();
    end

    // hang guard
    initial begin
        #3000000;
        failures++;
        $display("wrong value at %0t: timeout", $time);
        results();
    end
endmodule
